//--- cef_pkg.sv
/*
  Constants and carrier types for the CAN status, timing and filter block.
  Assumes one 50 MHz clock and a synchronous reset.
*/
package cef_pkg;

  // Clock rate and derived timing
  localparam int CLK_PERIOD_NS = 20;
  // Least time the receive line must stay dominant to count as filtered wake-up activity
  localparam int WAKE_FILT_NS = 100;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Information processing time in quanta, used when phase two follows phase one
  localparam logic [3:0] IPT_TQ = 4'h2;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_FLAGS = 3'h0;
  localparam logic [2:0] ADDR_ENABLES = 3'h1;
  localparam logic [2:0] ADDR_ERRCNT = 3'h2;
  localparam logic [2:0] ADDR_CFG_ONE = 3'h3;
  localparam logic [2:0] ADDR_CFG_TWO = 3'h4;
  localparam logic [2:0] ADDR_FLT_EN = 3'h5;
  localparam logic [2:0] ADDR_FLT_PTR = 3'h6;

  // Flag and enable bit positions
  localparam int BIT_TX_BUS_OFF = 13;
  localparam int BIT_TX_PASSIVE = 12;
  localparam int BIT_RX_PASSIVE = 11;
  localparam int BIT_TX_WARN = 10;
  localparam int BIT_RX_WARN = 9;
  localparam int BIT_ANY_WARN = 8;
  localparam int BIT_INVALID = 7;
  localparam int BIT_WAKE = 6;
  localparam int BIT_ERROR = 5;
  localparam int BIT_FIFO = 3;
  localparam int BIT_RX_OVF = 2;
  localparam int BIT_RX_BUF = 1;
  localparam int BIT_TX_BUF = 0;
  // Writable enable and clear-only flag bits
  localparam logic [7:0] IRQ_BITS_MASK = 8'hEF;

  // Configuration field positions
  localparam int SJW_LSB = 6;
  localparam int PRESC_LSB = 0;
  localparam int WAKE_FILT_BIT = 14;
  localparam int PH2_LSB = 8;
  localparam int PH2_SEL_BIT = 7;
  localparam int TRIPLE_BIT = 6;
  localparam int PH1_LSB = 3;
  localparam int PROP_LSB = 0;

  // Reset values
  localparam logic [7:0] ENABLES_RST = 8'h00;
  localparam logic [7:0] CFG_ONE_RST = 8'h00;
  localparam logic [15:0] CFG_TWO_RST = 16'h0000;
  localparam logic [15:0] FLT_EN_RST = 16'hFFFF;
  localparam logic [15:0] FLT_PTR_RST = 16'h0000;

  // Fault-confinement thresholds
  localparam logic [8:0] WARN_LIMIT = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
  localparam logic [8:0] BUS_OFF_LIMIT = 9'h100;
  localparam logic [8:0] ERR_STEP_BIG = 9'h008;

  // Bit-time segments, Gray coded along sync, prop, phase one, phase two
  typedef enum logic [1:0] {SEG_SYNC = 2'h0, SEG_PROP = 2'h1, SEG_PH1 = 2'h3, SEG_PH2 = 2'h2} cef_seg_e;

  // Single-cycle events from the protocol engine and buffer logic
  typedef struct packed {
    logic invalid_msg;
    logic fifo_almost_full;
    logic rx_overflow;
    logic rx_buffer;
    logic tx_buffer;
  } cef_evt_s;

  // Single-cycle fault-confinement events from the protocol engine
  typedef struct packed {
    logic tx_error;
    logic tx_ok;
    logic rx_error;
    logic rx_error_severe;
    logic rx_ok;
    logic bus_off_recover;
  } cef_err_evt_s;

  // Decoded bit-timing settings handed to the protocol engine
  typedef struct packed {
    logic [2:0] resync_jump_width;
    logic [3:0] propagation_length;
    logic [3:0] phase_one_length;
    logic [3:0] phase_two_length;
    logic triple_sample_sel;
  } cef_timing_s;

endpackage : cef_pkg

//--- cef_ctl.sv
/*
  CAN status, error counts, interrupt flags, bit timing and filter control.
  Assumes one-cycle event pulses on mclk and an asynchronous receive pin.
*/
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// How it works
// - Bit 13 shows transmitter bus-off
// - Bit 12 shows transmitter error-passive
// - Bit 11 shows receiver error-passive
// - Bits 10 and 9 show warning states
// - Bit 8 shows either side warning
// - Bit 5 set by fault states, clear-only
// - Bit 7 set on invalid message
// - Bit 6 set on bus wake activity
// - Bit 3 FIFO almost full; bit 4 zero
// - Bit 2 set on receive overflow
// - Bit 1 receive, bit 0 transmit events
// - Enables mirror flag bits, upper byte zero
// - Quantum is two times prescaler plus one
// - Propagation and phase one are field plus one
// - Phase two programmable or max(phase one, IPT)
// - Sample bit chooses three samples or one
// - Wake detection optionally uses line filter
// - Filter n active only while enabled
// - Pointer selects buffer 0-14 or FIFO
// - Four pointers packed in one register
module cef_ctl (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic can_rx_pin,
  input wire logic sleep_mode,
  input wire cef_pkg::cef_evt_s evt,
  input wire cef_pkg::cef_err_evt_s err_evt,
  output logic irq,
  output cef_pkg::cef_timing_s timing,
  output logic tq_tick,
  output logic sample_pulse,
  output logic sampled_bit,
  output logic [15:0] filter_n_enable,
  output logic [15:0] filter_dest_pointers
);

  ////////////////////////////////////////////////////////////////////////////////
  // Receive pin synchroniser and edge detection

  logic rx_meta_q; // First stage, read only by the second
  logic rx_sync_q, rx_prev_q; // Synchronised level and its previous value
  logic rx_fall; // Recessive to dominant transition
  // Two-stage synchroniser plus history flop
  always_ff @(posedge mclk)
  begin
    rx_meta_q <= sys_rst ? 1'b1 : can_rx_pin;
    rx_sync_q <= sys_rst ? 1'b1 : rx_meta_q;
    rx_prev_q <= sys_rst ? 1'b1 : rx_sync_q;
  end
  assign rx_fall = rx_prev_q & ~rx_sync_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0] ena_q, ena_d; // Interrupt enables
  logic [7:0] cfg1_q, cfg1_d; // Jump width and prescaler
  logic [15:0] cfg2_q, cfg2_d; // Segment lengths and options
  logic [15:0] flt_en_q, flt_en_d; // Acceptance filter enables
  logic [15:0] flt_ptr_q, flt_ptr_d; // Filter 0-3 destination pointers

  // Write decode for the plain writable registers
  always_comb
  begin
    ena_d = ena_q;
    cfg1_d = cfg1_q;
    cfg2_d = cfg2_q;
    flt_en_d = flt_en_q;
    flt_ptr_d = flt_ptr_q;
    if (reg_wr)
    begin
      case (reg_addr)
        cef_pkg::ADDR_ENABLES: ena_d = reg_wdata[7:0] & cef_pkg::IRQ_BITS_MASK;
        cef_pkg::ADDR_CFG_ONE: cfg1_d = reg_wdata[7:0];
        // Only the implemented bits 14 and 10-0 hold a value
        cef_pkg::ADDR_CFG_TWO: cfg2_d = reg_wdata & 16'h47FF;
        cef_pkg::ADDR_FLT_EN: flt_en_d = reg_wdata;
        cef_pkg::ADDR_FLT_PTR: flt_ptr_d = reg_wdata;
        default: ;
      endcase
    end
  end

  // Register stage for the configuration group
  always_ff @(posedge mclk)
  begin
    ena_q <= sys_rst ? cef_pkg::ENABLES_RST : ena_d;
    cfg1_q <= sys_rst ? cef_pkg::CFG_ONE_RST : cfg1_d;
    cfg2_q <= sys_rst ? cef_pkg::CFG_TWO_RST : cfg2_d;
    flt_en_q <= sys_rst ? cef_pkg::FLT_EN_RST : flt_en_d;
    flt_ptr_q <= sys_rst ? cef_pkg::FLT_PTR_RST : flt_ptr_d;
  end
  // Filter enables and pointers go straight to the acceptance logic;
  // pointer 4'hF routes to the FIFO, the rest to buffers 0-14
  assign filter_n_enable = flt_en_q;
  assign filter_dest_pointers = flt_ptr_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Decoded timing fields

  logic [3:0] prop_len, ph1_len, ph2_len; // Segment lengths in quanta
  logic [2:0] sjw_len; // Jump width in quanta
  logic [6:0] presc_top; // Last count of the quantum divider
  always_comb
  begin
    sjw_len = {1'b0, cfg1_q[cef_pkg::SJW_LSB +: 2]} + 3'h1;
    prop_len = {1'b0, cfg2_q[cef_pkg::PROP_LSB +: 3]} + 4'h1;
    ph1_len = {1'b0, cfg2_q[cef_pkg::PH1_LSB +: 3]} + 4'h1;
    if (cfg2_q[cef_pkg::PH2_SEL_BIT])
      ph2_len = {1'b0, cfg2_q[cef_pkg::PH2_LSB +: 3]} + 4'h1;
    else if (ph1_len > cef_pkg::IPT_TQ)
      ph2_len = ph1_len;
    else
      ph2_len = cef_pkg::IPT_TQ;
    // 2*(P+1) clocks per quantum, counted 0..2P+1
    presc_top = {cfg1_q[cef_pkg::PRESC_LSB +: 6], 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Quantum divider and bit-time sequencer

  logic [6:0] pc_q, pc_d; // Quantum prescaler count
  logic tq_q, tq_d; // One-cycle quantum enable
  cef_pkg::cef_seg_e seg_q, seg_d; // Current segment
  logic [3:0] tqc_q, tqc_d; // Quanta spent in the segment
  logic [2:0] ext_q, ext_d, shr_q, shr_d; // Phase one lengthening, phase two shortening
  logic resynced_q, resynced_d; // One resynchronisation per bit
  logic [2:0] hist_q, hist_d; // Line levels at the last quanta
  logic smp_q, smp_d, bit_q, bit_d; // Sample-point pulse and sampled value
  logic [3:0] ph1_end, ph2_end; // Phase one lengthened, phase two shortened
  // Segment walk, resynchronisation and sampling
  always_comb
  begin
    pc_d = pc_q + 7'h01;
    tq_d = 1'b0;
    seg_d = seg_q;
    tqc_d = tqc_q;
    ext_d = ext_q;
    shr_d = shr_q;
    resynced_d = resynced_q;
    hist_d = hist_q;
    smp_d = 1'b0;
    bit_d = bit_q;
    ph1_end = ph1_len + {1'b0, ext_q};
    ph2_end = ph2_len - {1'b0, shr_q};
    if (pc_q >= presc_top)
    begin
      pc_d = 7'h00;
      tq_d = 1'b1;
    end
    // Edge-driven resynchronisation, limited by the jump width
    if (rx_fall && !resynced_q && seg_q != cef_pkg::SEG_SYNC)
    begin
      resynced_d = 1'b1;
      if (seg_q == cef_pkg::SEG_PH2)
      begin
        // Edge late in phase two: it stands for the next sync segment
        if ((ph2_len - tqc_q) <= {1'b0, sjw_len})
        begin
          seg_d = cef_pkg::SEG_PROP;
          tqc_d = 4'h0;
          ext_d = 3'h0;
          shr_d = 3'h0;
          resynced_d = 1'b0;
          pc_d = 7'h00;
        end
        else
          shr_d = sjw_len;
      end
      else
        ext_d = sjw_len;
    end
    else if (tq_q)
    begin
      hist_d = {hist_q[1:0], rx_sync_q};
      tqc_d = tqc_q + 4'h1;
      case (seg_q)
        cef_pkg::SEG_SYNC:
        begin
          seg_d = cef_pkg::SEG_PROP;
          tqc_d = 4'h0;
          ext_d = 3'h0;
          shr_d = 3'h0;
          resynced_d = 1'b0;
        end
        cef_pkg::SEG_PROP:
          if (tqc_q + 4'h1 >= prop_len)
          begin
            seg_d = cef_pkg::SEG_PH1;
            tqc_d = 4'h0;
          end
        cef_pkg::SEG_PH1:
          if (tqc_q + 4'h1 >= ph1_end)
          begin
            // Sample point at the end of phase one
            seg_d = cef_pkg::SEG_PH2;
            tqc_d = 4'h0;
            smp_d = 1'b1;
            if (cfg2_q[cef_pkg::TRIPLE_BIT])
              bit_d = (hist_q[0] & hist_q[1]) | (hist_q[0] & rx_sync_q) | (hist_q[1] & rx_sync_q);
            else
              bit_d = rx_sync_q;
          end
        cef_pkg::SEG_PH2:
          if (tqc_q + 4'h1 >= ph2_end)
          begin
            seg_d = cef_pkg::SEG_SYNC;
            tqc_d = 4'h0;
          end
        default:
        begin
          seg_d = cef_pkg::SEG_SYNC;
          tqc_d = 4'h0;
        end
      endcase
    end
  end

  // Register stage for the sequencer
  always_ff @(posedge mclk)
  begin
    pc_q <= sys_rst ? 7'h00 : pc_d;
    tq_q <= sys_rst ? 1'b0 : tq_d;
    seg_q <= sys_rst ? cef_pkg::SEG_SYNC : seg_d;
    tqc_q <= sys_rst ? 4'h0 : tqc_d;
    ext_q <= sys_rst ? 3'h0 : ext_d;
    shr_q <= sys_rst ? 3'h0 : shr_d;
    resynced_q <= sys_rst ? 1'b0 : resynced_d;
    hist_q <= sys_rst ? 3'h7 : hist_d;
    smp_q <= sys_rst ? 1'b0 : smp_d;
    bit_q <= sys_rst ? 1'b1 : bit_d;
  end
  assign tq_tick = tq_q;
  assign sample_pulse = smp_q;
  assign sampled_bit = bit_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Wake-up detection

  logic [3:0] wk_cnt_q, wk_cnt_d; // Dominant run length
  logic wk_evt; // Wake activity seen this cycle

  // Filtered mode needs a dominant run, so glitches cannot wake the node
  always_comb
  begin
    wk_cnt_d = wk_cnt_q;
    wk_evt = 1'b0;
    if (rx_sync_q)
      wk_cnt_d = 4'h0;
    else if (wk_cnt_q != 4'hF)
      wk_cnt_d = wk_cnt_q + 4'h1;
    if (sleep_mode)
    begin
      if (cfg2_q[cef_pkg::WAKE_FILT_BIT])
        wk_evt = !rx_sync_q && (wk_cnt_q == 4'(cef_pkg::WAKE_FILT_CYC - 1));
      else
        wk_evt = rx_fall;
    end
  end

  always_ff @(posedge mclk)
  begin
    wk_cnt_q <= sys_rst ? 4'h0 : wk_cnt_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fault confinement counters

  logic [8:0] tec_q, tec_d; // Transmit errors, reaches 256 at bus-off
  logic [7:0] rec_q, rec_d; // Receive errors, saturating
  logic [5:0] fstate; // Status bits 13 down to 8

  // Counter updates; bus-off holds until the recovery event
  always_comb
  begin
    tec_d = tec_q;
    rec_d = rec_q;
    if (err_evt.bus_off_recover)
    begin
      tec_d = 9'h000;
      rec_d = 8'h00;
    end
    else
    begin
      if (tec_q < cef_pkg::BUS_OFF_LIMIT)
      begin
        if (err_evt.tx_error)
          tec_d = tec_q + cef_pkg::ERR_STEP_BIG;
        else if (err_evt.tx_ok && tec_q != 9'h000)
          tec_d = tec_q - 9'h001;
      end
      if (err_evt.rx_error_severe)
        rec_d = (rec_q > 8'hF7) ? 8'hFF : rec_q + 8'h08;
      else if (err_evt.rx_error && rec_q != 8'hFF)
        rec_d = rec_q + 8'h01;
      else if (err_evt.rx_ok && rec_q != 8'h00)
        rec_d = (rec_q > 8'h7F) ? 8'h77 : rec_q - 8'h01;
    end
    if (tec_d > cef_pkg::BUS_OFF_LIMIT)
      tec_d = cef_pkg::BUS_OFF_LIMIT;
  end

  always_ff @(posedge mclk)
  begin
    tec_q <= sys_rst ? 9'h000 : tec_d;
    rec_q <= sys_rst ? 8'h00 : rec_d;
  end
  // Thresholds 96, 128 and 256
  always_comb
  begin
    fstate[5] = tec_q >= cef_pkg::BUS_OFF_LIMIT;
    fstate[4] = !fstate[5] && tec_q >= cef_pkg::PASSIVE_LIMIT;
    fstate[3] = {1'b0, rec_q} >= cef_pkg::PASSIVE_LIMIT;
    fstate[2] = tec_q >= cef_pkg::WARN_LIMIT;
    fstate[1] = {1'b0, rec_q} >= cef_pkg::WARN_LIMIT;
    fstate[0] = fstate[2] | fstate[1];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt flags, request and read port

  logic [7:0] flag_q, flag_d; // Sticky flags, bit 4 always zero
  logic [5:0] fstate_q; // Previous fault states for rising detect
  logic [7:0] set_v; // Hardware set requests
  logic irq_q, irq_d; // Registered interrupt request
  logic [15:0] rdata_q, rdata_d; // Read data, valid the cycle after the strobe

  // Set wins over a clearing write in the same cycle
  always_comb
  begin
    set_v = 8'h00;
    set_v[cef_pkg::BIT_INVALID] = evt.invalid_msg;
    set_v[cef_pkg::BIT_WAKE] = wk_evt;
    set_v[cef_pkg::BIT_ERROR] = |(fstate & ~fstate_q);
    set_v[cef_pkg::BIT_FIFO] = evt.fifo_almost_full;
    set_v[cef_pkg::BIT_RX_OVF] = evt.rx_overflow;
    set_v[cef_pkg::BIT_RX_BUF] = evt.rx_buffer;
    set_v[cef_pkg::BIT_TX_BUF] = evt.tx_buffer;
    flag_d = flag_q;
    if (reg_wr && reg_addr == cef_pkg::ADDR_FLAGS)
      flag_d = flag_q & reg_wdata[7:0];
    flag_d = (flag_d | set_v) & cef_pkg::IRQ_BITS_MASK;
    irq_d = |(flag_d & ena_q);
    rdata_d = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        cef_pkg::ADDR_FLAGS: rdata_d = {2'b00, fstate, flag_q};
        cef_pkg::ADDR_ENABLES: rdata_d = {8'h00, ena_q};
        cef_pkg::ADDR_ERRCNT: rdata_d = {(tec_q[8] ? 8'hFF : tec_q[7:0]), rec_q};
        cef_pkg::ADDR_CFG_ONE: rdata_d = {8'h00, cfg1_q};
        cef_pkg::ADDR_CFG_TWO: rdata_d = cfg2_q;
        cef_pkg::ADDR_FLT_EN: rdata_d = flt_en_q;
        cef_pkg::ADDR_FLT_PTR: rdata_d = flt_ptr_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    flag_q <= sys_rst ? 8'h00 : flag_d;
    fstate_q <= sys_rst ? 6'h00 : fstate;
    irq_q <= sys_rst ? 1'b0 : irq_d;
    rdata_q <= sys_rst ? 16'h0000 : rdata_d;
  end
  assign irq = irq_q;
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing settings output, registered for a clean hand-off

  cef_pkg::cef_timing_s timing_q; // Decoded settings

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      timing_q <= '0;
    else
      timing_q <= {sjw_len, prop_len, ph1_len, ph2_len, cfg2_q[cef_pkg::TRIPLE_BIT]};
  end
  assign timing = timing_q;
endmodule : cef_ctl

//--- cef_ctl_assertions.sv
/*
  Port checks for cef_ctl.
  Assumes one mclk domain, synchronous sys_rst; bound to every cef_ctl.
*/
`timescale 1ns/1ps
module cef_ctl_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic tq_tick,
  input wire cef_pkg::cef_timing_s timing,
  input wire logic [15:0] filter_n_enable,
  input wire logic [15:0] filter_dest_pointers
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Read port: data only in the cycle after a strobe
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
  property p_flags_unused; $past(reg_rd) && $past(reg_addr) == cef_pkg::ADDR_FLAGS |-> reg_rdata[15:14] == 2'h0 && !reg_rdata[4]; endproperty
  a_flags_unused: assert property (p_flags_unused) else $error("unused flag bit set");
  property p_enables_upper; $past(reg_rd) && $past(reg_addr) == cef_pkg::ADDR_ENABLES |-> reg_rdata[15:8] == 8'h00 && !reg_rdata[4]; endproperty
  a_enables_upper: assert property (p_enables_upper) else $error("unused enable bit set");
  property p_ptr_read; $past(reg_rd) && $past(reg_addr) == cef_pkg::ADDR_FLT_PTR |-> reg_rdata == filter_dest_pointers; endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer readback differs");
  ////////////////////////////////////////////////////////////////////////////////
  // Timing: a quantum is at least two clocks, lengths stay in range
  property p_tq_gap; tq_tick |=> !tq_tick; endproperty
  a_tq_gap: assert property (p_tq_gap) else $error("quantum shorter than two clocks");
  property p_sjw_range; !$past(sys_rst) |-> timing.resync_jump_width inside {[3'h1:3'h4]}; endproperty
  a_sjw_range: assert property (p_sjw_range) else $error("jump width out of range");
  property p_seg_range; !$past(sys_rst) |-> timing.propagation_length inside {[4'h1:4'h8]} && timing.phase_one_length inside {[4'h1:4'h8]}; endproperty
  a_seg_range: assert property (p_seg_range) else $error("segment length out of range");
  property p_ph2_range; !$past(sys_rst) |-> timing.phase_two_length inside {[4'h1:4'h8]}; endproperty
  a_ph2_range: assert property (p_ph2_range) else $error("phase two out of range");
  ////////////////////////////////////////////////////////////////////////////////
  // Filter enables follow writes only
  property p_flt_write; reg_wr && reg_addr == cef_pkg::ADDR_FLT_EN |=> filter_n_enable == $past(reg_wdata); endproperty
  a_flt_write: assert property (p_flt_write) else $error("filter enable write lost");
  property p_flt_hold; !(reg_wr && reg_addr == cef_pkg::ADDR_FLT_EN) |=> $stable(filter_n_enable); endproperty
  a_flt_hold: assert property (p_flt_hold) else $error("filter enables changed unasked");
endmodule : cef_ctl_checker

bind cef_ctl cef_ctl_checker u_chk (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tq_tick(tq_tick), .timing(timing),
  .filter_n_enable(filter_n_enable), .filter_dest_pointers(filter_dest_pointers));

//--- cef_bus_model.sv
/*
  Transceiver and other nodes as seen on the receive pin.
  Assumes recessive high when undriven; bits last 160 ns.
*/
`timescale 1ns/1ps
module cef_bus_model (
  output logic can_rx_pin
);
  // Recessive when idle, as the transceiver shows an undriven bus
  initial can_rx_pin = 1'b1;
  // Single dominant burst, used for wake activity
  task dominant(input int ns);
    can_rx_pin = 1'b0;
    #(ns);
    can_rx_pin = 1'b1;
  endtask : dominant
  // Bit train, first bit sent is the top one, then back to recessive
  task send_bits(input logic [7:0] bits);
    for (int i = 7; i >= 0; i--)
    begin
      can_rx_pin = bits[i];
      #160;
    end
    can_rx_pin = 1'b1;
  endtask : send_bits
endmodule : cef_bus_model

//--- can_error_irq_timing_filter_ctl_test.sv
/*
  Self-checking bench for cef_ctl.
  Assumes the checker binds itself and the bus model drives the receive pin.
*/
`timescale 1ns/1ps
module can_error_irq_timing_filter_ctl_test;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_mode = 1'b0;
  cef_pkg::cef_evt_s evt = '0;
  cef_pkg::cef_err_evt_s err_evt = '0;
  logic [15:0] reg_rdata, filter_n_enable, filter_dest_pointers, rd_val;
  logic can_rx_pin, irq, tq_tick, sample_pulse, sampled_bit;
  cef_pkg::cef_timing_s timing;
  int failures = 0;
  int checked = 0;
  time t0;
  // Reset values by register index, index 7 unmapped
  logic [15:0] rst_tab [8] = '{5: 16'hFFFF, default: 16'h0000};
  logic [4:0] ev_tab [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
  int bit_tab [5] = '{7, 3, 2, 1, 0};
  // Second timing settings and the decoded lengths they must give
  logic [15:0] cfg_tab [4] = '{16'h0011, 16'h0000, 16'h0580, 16'h00C0};
  logic [15:0] tim_tab [4] = '{{3'h1, 4'h2, 4'h3, 4'h3, 1'h0}, {3'h1, 4'h1, 4'h1, 4'h2, 1'h0},
                               {3'h1, 4'h1, 4'h1, 4'h6, 1'h0}, {3'h1, 4'h1, 4'h1, 4'h1, 1'h1}};
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  initial
  begin
    forever #10 mclk = ~mclk;
  end
  cef_ctl dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .can_rx_pin(can_rx_pin), .sleep_mode(sleep_mode), .evt(evt),
    .err_evt(err_evt), .irq(irq), .timing(timing), .tq_tick(tq_tick), .sample_pulse(sample_pulse),
    .sampled_bit(sampled_bit), .filter_n_enable(filter_n_enable), .filter_dest_pointers(filter_dest_pointers));
  cef_bus_model far_end (.can_rx_pin(can_rx_pin));
  ////////////////////////////////////////////////////////////////////////////////
  // Access and compare tasks
  task chk16(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mask = 16'hFFFF);
    checked++;
    if ((got & mask) !== (exp & mask))
    begin
      failures++;
      $display("Error at %0t: got %h expected %h mask %h", $time, got, exp, mask);
    end
  endtask : chk16
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Strobe one cycle, data taken in the following cycle only
  task rchk(input logic [2:0] a, input logic [15:0] exp, input logic [15:0] mask = 16'hFFFF);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    chk16(rd_val, exp, mask);
  endtask : rchk
  task pulse_evt(input logic [4:0] e);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= '0;
  endtask : pulse_evt
  // Pulses are spaced by an idle cycle so each counts once
  task pulse_err(input logic [5:0] e, input int n);
    repeat (n)
    begin
      @(posedge mclk);
      err_evt <= e;
      @(posedge mclk);
      err_evt <= '0;
    end
  endtask : pulse_err
  // Bounded wait for a quantum tick (0) or sample pulse (1)
  task wait_high(input int which);
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1 n++;
    end while ((which ? sample_pulse : tq_tick) !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      failures++;
      $display("Error at %0t: pulse never came", $time);
    end
  endtask : wait_high
  task final_report;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the test length
  initial
  begin
    #400000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rchk(3'(i), rst_tab[i]);
    wr(cef_pkg::ADDR_FLAGS, 16'hFFFF);
    rchk(cef_pkg::ADDR_FLAGS, 16'h0000);
    wr(cef_pkg::ADDR_ERRCNT, 16'hFFFF);
    rchk(cef_pkg::ADDR_ERRCNT, 16'h0000);
    wr(cef_pkg::ADDR_ENABLES, 16'hFFFF);
    rchk(cef_pkg::ADDR_ENABLES, 16'h00EF);
    // Every buffer event: flag, request, then clear by writing zero
    for (int i = 0; i < 5; i++)
    begin
      pulse_evt(ev_tab[i]);
      @(posedge mclk);
      #1 chk16(16'(irq), 16'h0001);
      rchk(cef_pkg::ADDR_FLAGS, 16'h0001 << bit_tab[i], 16'h00FF);
      wr(cef_pkg::ADDR_FLAGS, ~(16'h0001 << bit_tab[i]));
      rchk(cef_pkg::ADDR_FLAGS, 16'h0000);
      chk16(16'(irq), 16'h0000);
    end
    // Masked event sets its flag but raises no request
    wr(cef_pkg::ADDR_ENABLES, 16'h0000);
    pulse_evt(5'h01);
    repeat (2) @(posedge mclk);
    #1 chk16(16'(irq), 16'h0000);
    rchk(cef_pkg::ADDR_FLAGS, 16'h0001);
    wr(cef_pkg::ADDR_FLAGS, 16'h0000);
    // Fault confinement walk through each threshold
    pulse_err(6'h20, 12);
    rchk(cef_pkg::ADDR_ERRCNT, 16'h6000);
    rchk(cef_pkg::ADDR_FLAGS, 16'h0520, 16'h0520);
    pulse_err(6'h20, 4);
    rchk(cef_pkg::ADDR_FLAGS, 16'h1000, 16'h1000);
    pulse_err(6'h08, 96);
    rchk(cef_pkg::ADDR_FLAGS, 16'h0200, 16'h0200);
    pulse_err(6'h08, 32);
    rchk(cef_pkg::ADDR_FLAGS, 16'h0800, 16'h0800);
    rchk(cef_pkg::ADDR_ERRCNT, 16'h8080);
    pulse_err(6'h20, 16);
    rchk(cef_pkg::ADDR_FLAGS, 16'h2000, 16'h2000);
    rchk(cef_pkg::ADDR_ERRCNT, 16'hFF80);
    pulse_err(6'h01, 1);
    rchk(cef_pkg::ADDR_ERRCNT, 16'h0000);
    rchk(cef_pkg::ADDR_FLAGS, 16'h0020, 16'h3F20);
    wr(cef_pkg::ADDR_FLAGS, 16'h0000);
    rchk(cef_pkg::ADDR_FLAGS, 16'h0000);
    // Each jump width code with a spread of prescalers
    for (int i = 0; i < 4; i++)
    begin
      wr(cef_pkg::ADDR_CFG_ONE, {8'hFF, 2'(i), 6'(i * 21)});
      rchk(cef_pkg::ADDR_CFG_ONE, {8'h00, 2'(i), 6'(i * 21)});
      chk16(16'(timing.resync_jump_width), 16'(i + 1), 16'h0007);
      wait_high(0);
      t0 = $time;
      wait_high(0);
      chk16(16'(($time - t0) / 20), 16'(2 * (i * 21 + 1)));
    end
    wr(cef_pkg::ADDR_CFG_ONE, 16'h0000);
    wr(cef_pkg::ADDR_CFG_TWO, 16'hFFFF);
    rchk(cef_pkg::ADDR_CFG_TWO, 16'h47FF);
    chk16(timing, {3'h1, 4'h8, 4'h8, 4'h8, 1'h1});
    for (int i = 0; i < 4; i++)
    begin
      wr(cef_pkg::ADDR_CFG_TWO, cfg_tab[i]);
      rchk(cef_pkg::ADDR_CFG_TWO, cfg_tab[i]);
      chk16(timing, tim_tab[i]);
    end
    // Wake activity, first without the line filter, then with it
    sleep_mode <= 1'b1;
    far_end.dominant(40);
    repeat (8) @(posedge mclk);
    rchk(cef_pkg::ADDR_FLAGS, 16'h0040, 16'h0040);
    wr(cef_pkg::ADDR_FLAGS, 16'h0000);
    wr(cef_pkg::ADDR_CFG_TWO, 16'h40C0);
    far_end.dominant(60);
    repeat (8) @(posedge mclk);
    rchk(cef_pkg::ADDR_FLAGS, 16'h0000, 16'h0040);
    far_end.dominant(200);
    repeat (8) @(posedge mclk);
    rchk(cef_pkg::ADDR_FLAGS, 16'h0040, 16'h0040);
    wr(cef_pkg::ADDR_FLAGS, 16'h0000);
    sleep_mode <= 1'b0;
    // Bit train at 160 ns per bit: four quanta of 40 ns, once and triple sampled
    for (int i = 0; i < 2; i++)
    begin
      wr(cef_pkg::ADDR_CFG_TWO, i ? 16'h00C0 : 16'h0080);
      fork
        far_end.send_bits(8'h00);
        begin
          #800;
          wait_high(1);
          chk16({15'h0000, sampled_bit}, 16'h0000, 16'h0001);
        end
      join
      #800;
      wait_high(1);
      chk16({15'h0000, sampled_bit}, 16'h0001, 16'h0001);
    end
    // Filter enables and buffer pointers reach their outputs
    wr(cef_pkg::ADDR_FLT_EN, 16'h5A3C);
    #1 chk16(filter_n_enable, 16'h5A3C);
    rchk(cef_pkg::ADDR_FLT_EN, 16'h5A3C);
    wr(cef_pkg::ADDR_FLT_PTR, 16'hF0E1);
    #1 chk16(filter_dest_pointers, 16'hF0E1);
    rchk(cef_pkg::ADDR_FLT_PTR, 16'hF0E1);
    final_report();
  end
endmodule : can_error_irq_timing_filter_ctl_test
